//--- hdl/pwr_seq.sv
// sleep and software standby sequencer with register port
//
// Notes on behaviour
// - halt with standby_select 0 enters sleep
// - cpu stops after halt, registers kept
// - peripherals run in sleep, module standby kept
// - accepted interrupt ends sleep, starts exception
// - source disabled in its module never wakes
// - masked non-nmi interrupts never end sleep
// - reset pin low in sleep forces reset
// - standby pin low in sleep: hardware standby
// - halt with standby_select 1 enters software standby
// - software standby resets and halts peripherals
// - registers, ram and port levels held
// - only nmi, irq0-2 or pins end standby
// - wake restarts oscillator, waits, then exception
// - disabled or masked irq0-2 keep standby
// - reset pin gives clocks at once, no wait
// - standby pin low in standby: hardware standby
// - wait is base times two to divide
// - nmi edge select chooses wake edge
// - standby_select stays 1 after interrupt exit
`timescale 1ns/1ns
`include "pwr_seq_map.svh"
module pwr_seq #(
	parameter int BASE_STATES  = `SETTLE_BASE_STATES,
	parameter int SHORT_STATES = `SETTLE_SHORT_STATES,
	parameter int N_EXT        = 3
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic [`ADDR_W-1:0]    i_addr,
	input  wire logic [`DATA_W-1:0]    i_wr_data,
	input  wire logic                  i_wr_stb,
	input  wire logic                  i_rd_stb,
	input  wire logic                  i_halt_exec,
	input  wire logic                  i_hard_init_pin_n,
	input  wire logic                  i_deep_halt_pin_n,
	input  wire logic                  i_nmi_pin,
	input  wire logic [N_EXT-1:0]      i_ext_irq_n,
	input  wire logic [N_EXT-1:0]      i_ext_irq_en,
	input  wire logic [N_EXT-1:0]      i_ext_irq_masked,
	input  wire logic                  i_periph_req,
	input  wire logic                  i_periph_src_en,
	input  wire logic                  i_periph_masked,
	output logic [`DATA_W-1:0]         o_rd_data,
	output pwr_seq_pkg::pwr_state_type o_state,
	output logic                       o_cpu_halt,
	output logic                       o_periph_run,
	output logic                       o_periph_reset,
	output logic                       o_osc_run,
	output logic                       o_clk_en,
	output logic                       o_port_hold,
	output logic                       o_hw_standby,
	output logic                       o_cpu_reset,
	output logic                       o_irq_exc_start,
	output logic                       o_reset_exc_start
);
	import pwr_seq_pkg::*;

	localparam int CW = `SETTLE_CNT_W;

	pwr_state_type          state_ff;
	pwr_state_type          nxt_state;
	logic [`DATA_W-1:0]     sys_ctrl_ff;
	logic [`DATA_W-1:0]     clk_div_ff;
	logic                   deep_halt_pin_n_wake;
	logic                   sleep_wake;
	logic                   settle_busy;
	logic                   settle_done;
	logic                   settle_start;
	logic [CW-1:0]          settle_term;
	logic [7:0]             nxt_ctl;
	logic                   nxt_irq_exc;
	logic                   nxt_reset_exc;

	// decode of the pin-level controls for a state
	// order: halt, run, prst, osc, clk, hold, hwstby, cpurst
	function automatic logic [7:0] ctl_of(input pwr_state_type s);
		logic [7:0] c;
		c = 8'h00;
		unique case (s)
			ST_RUN:        c = 8'b0101_1000;
			ST_SLEEP:      c = 8'b1101_1000;
			// peripherals reset, ports held, osc off
			ST_SW_DEEP_HALT_PIN_N:    c = 8'b1010_0100;
			ST_SETTLE:     c = 8'b1011_0100;
			ST_HW_DEEP_HALT_PIN_N:    c = 8'b1010_0011;
			// clocks supplied at once while reset held
			ST_RESET_HOLD: c = 8'b1011_1001;
			default:       c = 8'b1011_1001;
		endcase
		return c;
	endfunction : ctl_of

	// settling count from the settle and divide fields
	function automatic logic [CW-1:0] wait_states(input logic [2:0] sel,
	                                              input logic [1:0] div);
		logic [CW-1:0] base;
		logic [2:0]    s;
		s = sel;
		// illegal code falls back to the longest base
		if (s == `SETTLE_SEL_ILLEGAL) begin
			s = `SETTLE_SEL_LONGEST;
		end
		// base doubles per code, short code, divide shift
		if (s == `SETTLE_SEL_SHORT) begin
			base = CW'(SHORT_STATES);
		end else begin
			base = CW'(BASE_STATES) << s;
		end
		return base << div;
	endfunction : wait_states

	assign settle_term = wait_states(
		sys_ctrl_ff[`SYS_SETTLE_HI:`SYS_SETTLE_LO],
		{clk_div_ff[`DIV_HI_BIT], clk_div_ff[`DIV_LO_BIT]});

	wake_detect #(
		.N_EXT(N_EXT)
	) u_wake (
		.i_sys_clk       (i_sys_clk),
		.i_sys_rst       (i_sys_rst),
		.i_nmi_pin       (i_nmi_pin),
		.i_nmi_edge_sel  (sys_ctrl_ff[`SYS_NMI_EDGE_BIT]),
		.i_ext_irq_n     (i_ext_irq_n),
		.i_ext_irq_en    (i_ext_irq_en),
		.i_ext_irq_masked(i_ext_irq_masked),
		.i_periph_req    (i_periph_req),
		.i_periph_src_en (i_periph_src_en),
		.i_periph_masked (i_periph_masked),
		.o_deep_halt_pin_n_wake     (deep_halt_pin_n_wake),
		.o_sleep_wake    (sleep_wake)
	);

	settle_timer #(
		.CNT_W(CW)
	) u_settle (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_start  (settle_start),
		.i_clear  (nxt_state != ST_SETTLE && state_ff != ST_SW_DEEP_HALT_PIN_N),
		.i_term   (settle_term),
		.o_busy   (settle_busy),
		.o_done   (settle_done)
	);

	// pin priority: standby pin, then reset pin, then the sequence
	always_comb begin
		nxt_state     = state_ff;
		nxt_irq_exc   = 1'b0;
		nxt_reset_exc = 1'b0;
		settle_start  = 1'b0;
		if (!i_deep_halt_pin_n) begin
			// standby pin low goes to hardware standby
			nxt_state = ST_HW_DEEP_HALT_PIN_N;
		end else if (state_ff == ST_HW_DEEP_HALT_PIN_N) begin
			nxt_state = ST_RESET_HOLD;
		end else if (!i_hard_init_pin_n) begin
			// reset pin low forces reset, no wait
			nxt_state = ST_RESET_HOLD;
		end else begin
			unique case (state_ff)
				ST_RUN: begin
					if (i_halt_exec) begin
						if (sys_ctrl_ff[`SYS_DEEP_HALT_PIN_N_SEL_BIT]) begin
							nxt_state = ST_SW_DEEP_HALT_PIN_N;
						end else begin
							nxt_state = ST_SLEEP;
						end
					end
				end
				ST_SLEEP: begin
					if (sleep_wake) begin
						nxt_state   = ST_RUN;
						nxt_irq_exc = 1'b1;
					end
				end
				ST_SW_DEEP_HALT_PIN_N: begin
					if (deep_halt_pin_n_wake) begin
						nxt_state    = ST_SETTLE;
						settle_start = 1'b1;
					end
				end
				ST_SETTLE: begin
					if (settle_done) begin
						nxt_state   = ST_RUN;
						nxt_irq_exc = 1'b1;
					end
				end
				ST_RESET_HOLD: begin
					// reset exception on the pin rising
					nxt_state     = ST_RUN;
					nxt_reset_exc = 1'b1;
				end
				default: begin
					nxt_state = ST_RESET_HOLD;
				end
			endcase
		end
	end

	assign nxt_ctl = ctl_of(nxt_state);

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// outputs follow the next state so they line up with state_ff
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_state        <= ST_RUN;
			o_cpu_halt     <= 1'b0;
			o_periph_run   <= 1'b1;
			o_periph_reset <= 1'b0;
			o_osc_run      <= 1'b1;
			o_clk_en       <= 1'b1;
			o_port_hold    <= 1'b0;
			o_hw_standby   <= 1'b0;
			o_cpu_reset    <= 1'b0;
		end else begin
			o_state        <= nxt_state;
			o_cpu_halt     <= nxt_ctl[7];
			o_periph_run   <= nxt_ctl[6];
			o_periph_reset <= nxt_ctl[5];
			o_osc_run      <= nxt_ctl[4];
			o_clk_en       <= nxt_ctl[3];
			o_port_hold    <= nxt_ctl[2];
			o_hw_standby   <= nxt_ctl[1];
			o_cpu_reset    <= nxt_ctl[0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_irq_exc_start   <= 1'b0;
			o_reset_exc_start <= 1'b0;
		end else begin
			o_irq_exc_start   <= nxt_irq_exc;
			o_reset_exc_start <= nxt_reset_exc;
		end
	end

	// reset pin and hardware standby reinitialise the registers;
	// no hardware path clears standby_select on a wake
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || state_ff == ST_RESET_HOLD ||
		    state_ff == ST_HW_DEEP_HALT_PIN_N) begin
			sys_ctrl_ff <= `SYS_CTRL_RST;
			clk_div_ff  <= `CLK_DIV_RST;
		end else if (i_wr_stb) begin
			if (i_addr == `OFS_SYS_CTRL) begin
				sys_ctrl_ff <= i_wr_data;
			end
			if (i_addr == `OFS_CLK_DIV) begin
				clk_div_ff <= {6'h00, i_wr_data[1:0]};
			end
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || !i_rd_stb) begin
			o_rd_data <= 8'h00;
		end else begin
			unique case (i_addr)
				`OFS_SYS_CTRL: o_rd_data <= sys_ctrl_ff;
				`OFS_CLK_DIV:  o_rd_data <= clk_div_ff;
				`OFS_STATUS:   o_rd_data <= {2'b00, o_clk_en, o_osc_run,
				                             settle_busy, state_ff};
				default:       o_rd_data <= 8'h00;
			endcase
		end
	end
endmodule : pwr_seq

//--- hdl/pwr_seq_map.svh
// register offsets, field positions, reset values and settling constants
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH

`define ADDR_W               2
`define DATA_W               8

`define OFS_SYS_CTRL         2'h0
`define OFS_CLK_DIV          2'h1
`define OFS_STATUS           2'h2

`define SYS_DEEP_HALT_PIN_N_SEL_BIT     7
`define SYS_SETTLE_HI        6
`define SYS_SETTLE_LO        4
`define SYS_NMI_EDGE_BIT     3
`define SYS_CTRL_RST         8'h00

`define DIV_HI_BIT           1
`define DIV_LO_BIT           0
`define CLK_DIV_RST          8'h00

`define STAT_STATE_HI        2
`define STAT_SETTLE_BIT      3
`define STAT_OSC_BIT         4
`define STAT_CLK_BIT         5

`define SETTLE_BASE_STATES   8192
`define SETTLE_SHORT_STATES  1024
`define SETTLE_CNT_W         22
`define SETTLE_SEL_SHORT     3'h6
`define SETTLE_SEL_ILLEGAL   3'h7
`define SETTLE_SEL_LONGEST   3'h5

`endif

//--- hdl/pwr_seq_pkg.sv
// types shared by the power-down sequencer
package pwr_seq_pkg;
	typedef enum logic [2:0] {
		ST_RUN        = 3'b000,
		ST_SLEEP      = 3'b001,
		ST_SW_DEEP_HALT_PIN_N    = 3'b010,
		ST_SETTLE     = 3'b011,
		ST_HW_DEEP_HALT_PIN_N    = 3'b100,
		ST_RESET_HOLD = 3'b101
	} pwr_state_type;
endpackage : pwr_seq_pkg

//--- hdl/settle_timer.sv
// oscillator settling counter
`timescale 1ns/1ns
module settle_timer #(
	parameter int CNT_W = 22
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_start,
	input  wire logic             i_clear,
	input  wire logic [CNT_W-1:0] i_term,
	output logic                  o_busy,
	output logic                  o_done
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] term_ff;

	// term latched at start so a late register write cannot shorten it
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || i_clear) begin
			o_busy  <= 1'b0;
			cnt_ff  <= '0;
			term_ff <= '0;
		end else if (i_start) begin
			o_busy  <= 1'b1;
			cnt_ff  <= {{(CNT_W-1){1'b0}}, 1'b1};
			term_ff <= i_term;
		end else if (o_busy) begin
			if (cnt_ff == term_ff) begin
				o_busy <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || i_clear) begin
			o_done <= 1'b0;
		end else begin
			o_done <= o_busy && !i_start && (cnt_ff == term_ff);
		end
	end
endmodule : settle_timer

//--- hdl/wake_detect.sv
// nmi edge detection and qualification of wake requests
`timescale 1ns/1ns
module wake_detect #(
	parameter int N_EXT = 3
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_nmi_pin,
	input  wire logic             i_nmi_edge_sel,
	input  wire logic [N_EXT-1:0] i_ext_irq_n,
	input  wire logic [N_EXT-1:0] i_ext_irq_en,
	input  wire logic [N_EXT-1:0] i_ext_irq_masked,
	input  wire logic             i_periph_req,
	input  wire logic             i_periph_src_en,
	input  wire logic             i_periph_masked,
	output logic                  o_deep_halt_pin_n_wake,
	output logic                  o_sleep_wake
);
	logic nmi_prev_ff;
	logic nmi_edge;
	logic ext_wake;

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			nmi_prev_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= i_nmi_pin;
		end
	end

	// edge select: 0 falling, 1 rising
	assign nmi_edge = i_nmi_edge_sel ? (!nmi_prev_ff && i_nmi_pin)
	                                 : (nmi_prev_ff && !i_nmi_pin);
	assign ext_wake = |(~i_ext_irq_n & i_ext_irq_en & ~i_ext_irq_masked);
	// standby wakes on nmi or enabled irq0-2
	assign o_deep_halt_pin_n_wake  = nmi_edge || ext_wake;
	// sleep also wakes on a qualified peripheral
	assign o_sleep_wake = nmi_edge || ext_wake ||
	                      (i_periph_req && i_periph_src_en &&
	                       !i_periph_masked);
endmodule : wake_detect

//--- tb/pwr_seq_checker.sv
// port assertions for the power-down sequencer
`timescale 1ns/1ns
`include "pwr_seq_map.svh"
module pwr_seq_checker #(
	parameter int N_EXT = 3
) (
	input wire logic                       i_sys_clk,
	input wire logic                       i_sys_rst,
	input wire logic                       i_halt_exec,
	input wire logic                       i_hard_init_pin_n,
	input wire logic                       i_deep_halt_pin_n,
	input wire logic                       i_nmi_pin,
	input wire logic [N_EXT-1:0]           i_ext_irq_n,
	input wire logic [N_EXT-1:0]           i_ext_irq_en,
	input wire logic [N_EXT-1:0]           i_ext_irq_masked,
	input wire logic                       i_periph_req,
	input wire logic                       i_periph_src_en,
	input wire logic                       i_periph_masked,
	input wire pwr_seq_pkg::pwr_state_type o_state,
	input wire logic                       o_cpu_halt,
	input wire logic                       o_periph_run,
	input wire logic                       o_periph_reset,
	input wire logic                       o_osc_run,
	input wire logic                       o_clk_en,
	input wire logic                       o_port_hold,
	input wire logic                       o_hw_standby,
	input wire logic                       o_cpu_reset,
	input wire logic                       o_irq_exc_start,
	input wire logic                       o_reset_exc_start
);
	import pwr_seq_pkg::*;
	wire pins_hi = i_hard_init_pin_n && i_deep_halt_pin_n;
	wire no_ext = &(i_ext_irq_n | ~i_ext_irq_en | i_ext_irq_masked);
	wire no_per = !i_periph_req || !i_periph_src_en || i_periph_masked;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	a_halt_enters: assert property (
		o_state == ST_RUN && i_halt_exec && pins_hi
		|=> o_state inside {ST_SLEEP, ST_SW_DEEP_HALT_PIN_N}) else $error("halt lost");
	a_sleep_live: assert property (
		o_state == ST_SLEEP |-> o_cpu_halt && o_periph_run && o_clk_en)
		else $error("sleep outs");
	a_deep_halt_pin_n_frozen: assert property (
		o_state == ST_SW_DEEP_HALT_PIN_N
		|-> !o_osc_run && !o_clk_en && o_periph_reset && o_port_hold)
		else $error("standby outs");
	a_init_pin: assert property (
		!i_hard_init_pin_n && i_deep_halt_pin_n
		|=> o_state == ST_RESET_HOLD && o_clk_en && o_osc_run)
		else $error("reset pin");
	a_deep_pin: assert property (
		!i_deep_halt_pin_n |=> o_state == ST_HW_DEEP_HALT_PIN_N)
		else $error("standby pin");
	a_init_release: assert property (
		o_state == ST_RESET_HOLD && pins_hi
		|=> o_state == ST_RUN && o_reset_exc_start) else $error("reset exit");
	a_exc_pulse: assert property (
		o_irq_exc_start
		|-> $past(o_state) inside {ST_SLEEP, ST_SETTLE} ##1 !o_irq_exc_start)
		else $error("exception pulse");
	a_settle_gate: assert property (
		o_state == ST_SETTLE |-> o_osc_run && !o_clk_en)
		else $error("settle clocks");
	a_deep_halt_pin_n_holds: assert property (
		o_state == ST_SW_DEEP_HALT_PIN_N && pins_hi && $stable(i_nmi_pin) && no_ext
		|=> o_state == ST_SW_DEEP_HALT_PIN_N) else $error("standby left");
	a_sleep_holds: assert property (
		o_state == ST_SLEEP && pins_hi && $stable(i_nmi_pin) && no_ext
		&& no_per |=> o_state == ST_SLEEP) else $error("sleep left");
	a_hw_outs: assert property (
		o_state == ST_HW_DEEP_HALT_PIN_N
		|-> o_hw_standby && o_cpu_reset && !o_clk_en && !o_osc_run)
		else $error("hardware standby outs");
	a_reset_outs: assert property (
		o_state == ST_RESET_HOLD |-> o_cpu_reset && !o_hw_standby)
		else $error("reset hold outs");
endmodule : pwr_seq_checker

//--- tb/cpu_pin_model.sv
// cpu core, interrupt logic and pin side of the sequencer
`timescale 1ns/1ns
module cpu_pin_model #(
	parameter int N_EXT    = 3,
	parameter int HOLD_CYC = 6
) (
	input  wire logic        i_sys_clk,
	output logic             o_halt_exec,
	output logic             o_hard_init_pin_n,
	output logic             o_deep_halt_pin_n,
	output logic             o_nmi_pin,
	output logic [N_EXT-1:0] o_ext_irq_n,
	output logic [N_EXT-1:0] o_ext_irq_en,
	output logic [N_EXT-1:0] o_ext_irq_masked,
	output logic             o_periph_req,
	output logic             o_periph_src_en,
	output logic             o_periph_masked
);
	initial begin
		{o_halt_exec, o_nmi_pin, o_periph_req} = 3'h0;
		{o_periph_src_en, o_periph_masked} = 2'h0;
		{o_hard_init_pin_n, o_deep_halt_pin_n} = 2'h3;
		o_ext_irq_n = '1;
		o_ext_irq_en = '0;
		o_ext_irq_masked = '0;
	end
	task automatic halt();
		@(posedge i_sys_clk);
		o_halt_exec <= 1'b1;
		@(posedge i_sys_clk);
		o_halt_exec <= 1'b0;
	endtask : halt
	task automatic pulse_init();
		@(posedge i_sys_clk);
		o_hard_init_pin_n <= 1'b0;
		repeat (HOLD_CYC) @(posedge i_sys_clk);
		o_hard_init_pin_n <= 1'b1;
	endtask : pulse_init
endmodule : cpu_pin_model

//--- tb/test_pwr_seq.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/1ns
`include "pwr_seq_map.svh"
module test_pwr_seq;
	import pwr_seq_pkg::*;
	localparam int BASE = 16;
	localparam int SHORT = 4;
	logic               i_sys_clk;
	logic               i_sys_rst;
	logic [`ADDR_W-1:0] i_addr;
	logic [`DATA_W-1:0] i_wr_data;
	logic               i_wr_stb;
	logic               i_rd_stb;
	wire logic          halt, init_n, deep_n, nmi, p_req, p_en, p_msk;
	wire logic [2:0]    irq_n, irq_en, irq_msk;
	wire logic [7:0]    rdata;
	pwr_state_type      st;
	wire logic          exc, rexc, clk_en;
	int                 n_mismatch = 0;
	int                 checks_done = 0;
	cpu_pin_model far (.i_sys_clk, .o_halt_exec(halt),
		.o_hard_init_pin_n(init_n), .o_deep_halt_pin_n(deep_n),
		.o_nmi_pin(nmi), .o_ext_irq_n(irq_n), .o_ext_irq_en(irq_en),
		.o_ext_irq_masked(irq_msk), .o_periph_req(p_req),
		.o_periph_src_en(p_en), .o_periph_masked(p_msk));
	pwr_seq #(.BASE_STATES(BASE), .SHORT_STATES(SHORT)) dut (
		.i_sys_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
		.i_halt_exec(halt), .i_hard_init_pin_n(init_n),
		.i_deep_halt_pin_n(deep_n), .i_nmi_pin(nmi), .i_ext_irq_n(irq_n),
		.i_ext_irq_en(irq_en), .i_ext_irq_masked(irq_msk),
		.i_periph_req(p_req), .i_periph_src_en(p_en),
		.i_periph_masked(p_msk), .o_rd_data(rdata), .o_state(st),
		.o_cpu_halt(), .o_periph_run(), .o_periph_reset(), .o_osc_run(),
		.o_clk_en(clk_en), .o_port_hold(), .o_hw_standby(),
		.o_cpu_reset(), .o_irq_exc_start(exc), .o_reset_exc_start(rexc));
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : cyc
	task automatic tmo(input logic ok);
		if (ok !== 1'b1) begin
			chk(1'b0, "wait ran out");
			summarize();
		end
	endtask : tmo
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_stb <= 1'b1;
		@(posedge i_sys_clk);
		i_wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] e, string m);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_stb <= 1'b0;
		#1;
		chk(rdata === e, m);
	endtask : rd
	task automatic t_regs();
		rd(0, 8'h00, "ctrl reset");
		rd(2, 8'h30, "status run");
		wr(1, 8'h03);
		rd(1, 8'h03, "divide rw");
		wr(3, 8'hFF);
		rd(3, 8'h00, "unmapped");
		$display("test regs done");
	endtask : t_regs
	task automatic t_sleep();
		wr(0, 8'h00);
		far.halt();
		#1;
		chk(st === ST_SLEEP, "sleep entry");
		@(posedge i_sys_clk);
		far.o_ext_irq_n <= 3'b110;
		far.o_ext_irq_en <= 3'b001;
		far.o_ext_irq_masked <= 3'b001;
		far.o_periph_req <= 1'b1;
		cyc(4);
		chk(st === ST_SLEEP, "masked wake");
		far.o_periph_src_en <= 1'b1;
		far.o_periph_masked <= 1'b1;
		cyc(2);
		chk(st === ST_SLEEP, "masked periph");
		far.o_periph_masked <= 1'b0;
		cyc(1);
		chk(exc === 1'b1 && st === ST_RUN, "sleep wake");
		far.o_ext_irq_n <= 3'b111;
		far.o_periph_req <= 1'b0;
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_deep_halt_pin_n(input logic [2:0] c, input logic [1:0] d);
		int n;
		int k;
		logic e;
		n = ((c == 3'h6) ? SHORT : BASE << ((c == 3'h7) ? 5 : c)) << d;
		e = ~nmi;
		wr(0, {1'b1, c, e, 3'b000});
		wr(1, {6'h00, d});
		far.halt();
		#1;
		chk(st === ST_SW_DEEP_HALT_PIN_N, "standby entry");
		far.o_ext_irq_n <= 3'b000;
		far.o_ext_irq_en <= 3'b011;
		far.o_ext_irq_masked <= 3'b011;
		// qualified peripheral request must not end standby
		far.o_periph_req <= 1'b1;
		cyc(4);
		chk(st === ST_SW_DEEP_HALT_PIN_N, "masked irq woke");
		far.o_nmi_pin <= e;
		far.o_ext_irq_n <= 3'b111;
		far.o_periph_req <= 1'b0;
		k = 0;
		while (exc !== 1'b1 && k < n + 8) begin
			cyc(1);
			k++;
		end
		tmo(exc);
		chk(k == n + 2 && clk_en === 1'b1, "settle");
		rd(0, {1'b1, c, e, 3'b000}, "select kept");
		$display("test standby %0d done", c);
	endtask : t_deep_halt_pin_n
	task automatic t_pins();
		int k;
		wr(0, 8'h80);
		far.halt();
		far.pulse_init();
		cyc(1);
		chk(rexc === 1'b1 && st === ST_RUN, "reset exit");
		rd(0, 8'h00, "ctrl cleared");
		far.halt();
		far.o_deep_halt_pin_n <= 1'b0;
		cyc(2);
		chk(st === ST_HW_DEEP_HALT_PIN_N, "deep pin");
		wr(0, 8'h80);
		far.o_deep_halt_pin_n <= 1'b1;
		for (k = 0; k < 20 && st !== ST_RUN; k++)
			cyc(1);
		tmo(st === ST_RUN);
		rd(0, 8'h00, "write in standby");
		wr(0, 8'h80);
		far.halt();
		far.o_deep_halt_pin_n <= 1'b0;
		cyc(2);
		chk(st === ST_HW_DEEP_HALT_PIN_N, "deep pin standby");
		far.o_deep_halt_pin_n <= 1'b1;
		for (k = 0; k < 20 && st !== ST_RUN; k++)
			cyc(1);
		tmo(st === ST_RUN);
		$display("test pins done");
	endtask : t_pins
	initial begin
		{i_sys_rst, i_wr_stb, i_rd_stb} = 3'b100;
		i_addr = '0;
		i_wr_data = '0;
		repeat (12) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_regs();
		t_sleep();
		for (int c = 0; c < 8; c++)
			t_deep_halt_pin_n(c[2:0], c[1:0]);
		t_pins();
		summarize();
	end
endmodule : test_pwr_seq
bind pwr_seq pwr_seq_checker #(.N_EXT(N_EXT)) u_chk (
	.i_sys_clk, .i_sys_rst, .i_halt_exec, .i_hard_init_pin_n,
	.i_deep_halt_pin_n, .i_nmi_pin, .i_ext_irq_n, .i_ext_irq_en,
	.i_ext_irq_masked, .i_periph_req, .i_periph_src_en, .i_periph_masked,
	.o_state, .o_cpu_halt, .o_periph_run, .o_periph_reset, .o_osc_run,
	.o_clk_en, .o_port_hold, .o_hw_standby, .o_cpu_reset,
	.o_irq_exc_start, .o_reset_exc_start);
